// ### src/dsm_pkg.sv
package dsm_pkg;
  // APB map, byte addresses of aligned 32-bit words
  localparam logic [7:0] OFF_MAIN_STATUS = 8'h00;
  localparam logic [7:0] OFF_SECOND_STATUS = 8'h04;
  localparam logic [7:0] OFF_MESSAGES_ONE = 8'h08;
  localparam logic [7:0] OFF_MESSAGES_TWO = 8'h0C;
  localparam logic [7:0] OFF_FREQ_THR_ONE = 8'h10;
  localparam logic [7:0] OFF_CURRENT_THR = 8'h14;
  localparam logic [7:0] OFF_DC_LINK_THR = 8'h18;
  localparam logic [7:0] OFF_CTRL_UPPER = 8'h1C;
  localparam logic [7:0] OFF_CTRL_LOWER = 8'h20;
  localparam logic [7:0] OFF_FREQ_MIN = 8'h24;
  localparam logic [7:0] OFF_FREQ_OFF = 8'h28;
  localparam logic [7:0] OFF_FREQ_MAX = 8'h2C;
  localparam logic [7:0] OFF_TORQUE_THR = 8'h30;
  localparam logic [7:0] OFF_BIT_SELECT = 8'h34;
  localparam logic [7:0] OFF_BIT_VALUE = 8'h38;

  // Reset values of the writable registers
  localparam logic [15:0] RST_FREQ_THR_ONE = 16'h0000;
  localparam logic [15:0] RST_CURRENT_THR = 16'h0000;
  localparam logic [15:0] RST_DC_LINK_THR = 16'h0000;
  localparam logic [15:0] RST_CTRL_UPPER = 16'h7FFF;
  localparam logic [15:0] RST_CTRL_LOWER = 16'h8000;
  localparam logic [15:0] RST_FREQ_MIN = 16'h0000;
  localparam logic [15:0] RST_FREQ_OFF = 16'h0000;
  localparam logic [15:0] RST_FREQ_MAX = 16'h7FFF;
  localparam logic [15:0] RST_TORQUE_THR = 16'h7FFF;
  localparam logic [5:0] RST_BIT_SELECT = 6'h00;

  // Bit select register: word number in [1:0], bit number in [7:4]
  localparam int SEL_WORD_LSB = 0;
  localparam int SEL_BIT_LSB = 4;

  // Main status word fields
  localparam int MS_READY = 0;
  localparam int MS_READY_RUN = 1;
  localparam int MS_RUNNING = 2;
  localparam int MS_FAULT = 3;
  localparam int MS_COAST = 4;
  localparam int MS_QUICK = 5;
  localparam int MS_INHIBIT = 6;
  localparam int MS_WARNING = 7;
  localparam int MS_DEVIATION = 8;
  localparam int MS_PD_CTRL = 9;
  localparam int MS_FMAX_REACHED = 10;
  localparam int MS_CUR_LIMIT = 11;
  localparam int MS_BRAKE = 12;
  localparam int MS_MOTOR_OVL = 13;
  localparam int MS_CLOCKWISE = 14;
  localparam int MS_DRIVE_OVL = 15;

  // Second status word fields
  localparam int SS_DC_BRAKE = 0;
  localparam int SS_F_GE_OFF = 1;
  localparam int SS_F_GT_MIN = 2;
  localparam int SS_I_GE_THR = 3;
  localparam int SS_F_GT_ONE = 4;
  localparam int SS_F_LE_ONE = 5;
  localparam int SS_F_GE_SET = 6;
  localparam int SS_VDC_LOW = 7;
  localparam int SS_VDC_HIGH = 8;
  localparam int SS_RAMP_DONE = 9;
  localparam int SS_CTRL_AT_LOW = 10;
  localparam int SS_CTRL_AT_HIGH = 11;

  // Message word one fields
  localparam int M1_F_GT_MIN = 0;
  localparam int M1_F_LE_ONE = 1;
  localparam int M1_F_GT_ONE = 2;
  localparam int M1_F_GT_ZERO = 3;
  localparam int M1_F_GE_SET = 4;
  localparam int M1_F_GE_OFF = 5;
  localparam int M1_F_GT_MAX = 6;
  localparam int M1_F_EQ_SET = 7;
  localparam int M1_I_GE_THR = 8;
  localparam int M1_VDC_LOW = 9;
  localparam int M1_VDC_HIGH = 10;
  localparam int M1_NO_LOAD = 11;

  // Message word two fields
  localparam int M2_FSET_GT_ZERO = 5;
  localparam int M2_BLOCKED = 6;
  localparam int M2_STALLED = 7;
  localparam int M2_I_LT_THR = 8;
  localparam int M2_TRQ_AT_SET = 9;
  localparam int M2_TRQ_HIGH = 10;
  localparam int M2_LOAD_WARN = 11;
  localparam int M2_LOAD_FAULT = 12;

  // Monitoring cycle timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MON_PERIOD_NS = 1000;
  localparam int MON_CYCLES = MON_PERIOD_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 7;
  localparam logic [CNT_W-1:0] MON_LAST = CNT_W'(MON_CYCLES - 1);
endpackage

// ### src/dsm_status_top.sv
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
// How it works
// - Results kept in read-only words, bits addressable.
// - Main bits 0-3: ready, ready-run, running, fault.
// - Main bits 4-7: coast, quick stop, inhibit, warning.
// - Main bits 8-11: deviation, process data, fmax, current.
// - Main bits 12-15: brake, motor overload, clockwise, overload.
// - Second bits 0,9,10,11: DC brake, ramp, limits.
// - Frequency at/above and equal setpoint flags.
// - Current at/above and below threshold flags.
// - DC link below and above threshold flags.
// - Absolute frequency versus first threshold flags.
// - Message two bits 11,12: load torque warn, fault.
module dsm_status_top
  import dsm_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Measured values; current and DC link unsigned, the rest two's complement
  input wire logic [15:0] freq_actual,
  input wire logic [15:0] freq_setpoint,
  input wire logic [15:0] actual_current_value,
  input wire logic [15:0] dc_link_voltage,
  input wire logic [15:0] torque_actual,
  input wire logic [15:0] controller_output_value,
  // Drive state flags
  input wire logic st_ready,
  input wire logic st_ready_run,
  input wire logic st_running,
  input wire logic st_fault,
  input wire logic coast_stop,
  input wire logic quick_stop,
  input wire logic st_inhibit,
  input wire logic st_warning,
  input wire logic st_deviation,
  input wire logic process_data_control,
  input wire logic st_current_limit,
  input wire logic st_brake,
  input wire logic st_motor_overload,
  input wire logic st_drive_overload,
  input wire logic st_dc_brake,
  input wire logic st_ramp_done,
  input wire logic st_no_load,
  input wire logic st_blocked,
  input wire logic st_stalled,
  input wire logic load_torque_warn,
  input wire logic load_torque_fault,
  // Word and bit outputs
  output logic [15:0] drive_main_status,
  output logic [15:0] drive_second_status,
  output logic [15:0] monitor_messages_one,
  output logic [15:0] monitor_messages_two
);
  ////////////////////////////////////////////////////////////////////////////
  localparam int FLAG_W = 21;
  localparam int SYNC_W = 6 * 16 + FLAG_W;
  logic [SYNC_W-1:0] sync_out; // Synchronised pins
  logic signed [15:0] f_act, f_set, trq, ctl; // Signed views
  logic [15:0] i_act, vdc; // Unsigned views
  logic [FLAG_W-1:0] fl; // Synchronised flags
  // Values are multi-bit; a word caught mid-change can mix old and new bits for one sample
  dsm_sync #(.W(SYNC_W)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({freq_actual, freq_setpoint, actual_current_value, dc_link_voltage,
          torque_actual, controller_output_value,
          load_torque_fault, load_torque_warn, st_stalled, st_blocked,
          st_no_load, st_ramp_done, st_dc_brake, st_drive_overload,
          st_motor_overload, st_brake, st_current_limit, process_data_control,
          st_deviation, st_warning, st_inhibit, quick_stop, coast_stop,
          st_fault, st_running, st_ready_run, st_ready}),
    .dout(sync_out)
  );
  assign f_act = sync_out[SYNC_W-1 -: 16];
  assign f_set = sync_out[SYNC_W-17 -: 16];
  assign i_act = sync_out[SYNC_W-33 -: 16];
  assign vdc = sync_out[SYNC_W-49 -: 16];
  assign trq = sync_out[SYNC_W-65 -: 16];
  assign ctl = sync_out[SYNC_W-81 -: 16];
  assign fl = sync_out[FLAG_W-1:0];
  // Magnitude; the most negative value maps to 16'h8000
  function automatic logic [15:0] mag(input logic [15:0] v);
    mag = v[15] ? 16'((~v) + 16'h0001) : v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Monitoring cycle tick
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic tick_q, tick_d; // One-cycle pulse each monitoring cycle
  always_comb begin
    cnt_d = (cnt_q == MON_LAST) ? '0 : cnt_q + 1'b1;
    tick_d = (cnt_q == MON_LAST);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Threshold registers written by software
  logic [15:0] f_one_q, f_one_d, i_thr_q, i_thr_d, vdc_thr_q, vdc_thr_d;
  logic [15:0] up_q, up_d, lo_q, lo_d, fmin_q, fmin_d, foff_q, foff_d;
  logic [15:0] fmax_q, fmax_d, tthr_q, tthr_d;
  logic [5:0] sel_q, sel_d; // Word and bit of the bit read port
  logic wr_en; // Write completes this edge
  assign wr_en = psel & penable & pready & pwrite;
  // Writes take effect at the completing access edge only
  always_comb begin
    f_one_d = f_one_q;
    i_thr_d = i_thr_q;
    vdc_thr_d = vdc_thr_q;
    up_d = up_q;
    lo_d = lo_q;
    fmin_d = fmin_q;
    foff_d = foff_q;
    fmax_d = fmax_q;
    tthr_d = tthr_q;
    sel_d = sel_q;
    if (wr_en) begin
      case (paddr)
        OFF_FREQ_THR_ONE: f_one_d = pwdata[15:0];
        OFF_CURRENT_THR: i_thr_d = pwdata[15:0];
        OFF_DC_LINK_THR: vdc_thr_d = pwdata[15:0];
        OFF_CTRL_UPPER: up_d = pwdata[15:0];
        OFF_CTRL_LOWER: lo_d = pwdata[15:0];
        OFF_FREQ_MIN: fmin_d = pwdata[15:0];
        OFF_FREQ_OFF: foff_d = pwdata[15:0];
        OFF_FREQ_MAX: fmax_d = pwdata[15:0];
        OFF_TORQUE_THR: tthr_d = pwdata[15:0];
        OFF_BIT_SELECT: sel_d = {pwdata[SEL_BIT_LSB+3 -: 4], pwdata[SEL_WORD_LSB+1 -: 2]};
        default: ; // Status words are read-only
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      f_one_q <= RST_FREQ_THR_ONE;
      i_thr_q <= RST_CURRENT_THR;
      vdc_thr_q <= RST_DC_LINK_THR;
      up_q <= RST_CTRL_UPPER;
      lo_q <= RST_CTRL_LOWER;
      fmin_q <= RST_FREQ_MIN;
      foff_q <= RST_FREQ_OFF;
      fmax_q <= RST_FREQ_MAX;
      tthr_q <= RST_TORQUE_THR;
      sel_q <= RST_BIT_SELECT;
    end else begin
      f_one_q <= f_one_d;
      i_thr_q <= i_thr_d;
      vdc_thr_q <= vdc_thr_d;
      up_q <= up_d;
      lo_q <= lo_d;
      fmin_q <= fmin_d;
      foff_q <= foff_d;
      fmax_q <= fmax_d;
      tthr_q <= tthr_d;
      sel_q <= sel_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status evaluation: all four words load on the same tick edge
  logic [15:0] ms_q, ms_d, ss_q, ss_d, m1_q, m1_d, m2_q, m2_d;
  logic [15:0] fa; // Absolute actual frequency
  logic f_eq_set; // Actual equals setpoint
  assign fa = mag(f_act);
  assign f_eq_set = (f_act == f_set);
  always_comb begin
    ms_d = ms_q;
    ss_d = ss_q;
    m1_d = m1_q;
    m2_d = m2_q;
    if (tick_q) begin
      ms_d = {fl[13], (f_act > 16'sh0000), fl[12:10], (fa >= fmax_q), fl[9:0]};
      ss_d = '0;
      ss_d[SS_DC_BRAKE] = fl[14];
      ss_d[SS_RAMP_DONE] = fl[15];
      ss_d[SS_CTRL_AT_LOW] = (ctl == $signed(lo_q));
      ss_d[SS_CTRL_AT_HIGH] = (ctl == $signed(up_q));
      ss_d[SS_F_GE_OFF] = (fa >= foff_q);
      ss_d[SS_F_GT_MIN] = (fa > fmin_q);
      ss_d[SS_I_GE_THR] = (i_act >= i_thr_q);
      ss_d[SS_F_GT_ONE] = (fa > f_one_q);
      ss_d[SS_F_LE_ONE] = (fa <= f_one_q);
      ss_d[SS_F_GE_SET] = (f_act >= f_set);
      ss_d[SS_VDC_LOW] = (vdc < vdc_thr_q);
      ss_d[SS_VDC_HIGH] = (vdc > vdc_thr_q);
      m1_d = '0;
      m1_d[M1_F_GT_MIN] = (fa > fmin_q);
      m1_d[M1_F_LE_ONE] = (fa <= f_one_q);
      m1_d[M1_F_GT_ONE] = (fa > f_one_q);
      m1_d[M1_F_GT_ZERO] = (fa != 16'h0000);
      m1_d[M1_F_GE_SET] = (f_act >= f_set);
      m1_d[M1_F_GE_OFF] = (fa >= foff_q);
      m1_d[M1_F_GT_MAX] = (fa > fmax_q);
      m1_d[M1_F_EQ_SET] = f_eq_set;
      m1_d[M1_I_GE_THR] = (i_act >= i_thr_q);
      m1_d[M1_VDC_LOW] = (vdc < vdc_thr_q);
      m1_d[M1_VDC_HIGH] = (vdc > vdc_thr_q);
      m1_d[M1_NO_LOAD] = fl[16];
      m2_d = '0;
      m2_d[M2_FSET_GT_ZERO] = (f_set > 16'sh0000);
      m2_d[M2_BLOCKED] = fl[17];
      m2_d[M2_STALLED] = fl[18];
      m2_d[M2_I_LT_THR] = (i_act < i_thr_q);
      m2_d[M2_TRQ_AT_SET] = (mag(trq) > tthr_q) & f_eq_set;
      m2_d[M2_TRQ_HIGH] = (mag(trq) > tthr_q);
      m2_d[M2_LOAD_WARN] = fl[19];
      m2_d[M2_LOAD_FAULT] = fl[20];
    end
  end
  // Words drive the ports straight from these flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_q <= '0;
      ss_q <= '0;
      m1_q <= '0;
      m2_q <= '0;
    end else begin
      ms_q <= ms_d;
      ss_q <= ss_d;
      m1_q <= m1_d;
      m2_q <= m2_d;
    end
  end
  assign drive_main_status = ms_q;
  assign drive_second_status = ss_q;
  assign monitor_messages_one = m1_q;
  assign monitor_messages_two = m2_q;

  ////////////////////////////////////////////////////////////////////////////
  // APB answer: read data formed in setup, one access cycle, no waits
  logic [31:0] rd_q, rd_d;
  logic rdy_q, rdy_d, err_q, err_d;
  logic [15:0] sel_word; // Word chosen by the bit read port
  logic bit_val; // Selected single bit
  always_comb begin
    case (sel_q[1:0])
      2'h0: sel_word = ms_q;
      2'h1: sel_word = ss_q;
      2'h2: sel_word = m1_q;
      default: sel_word = m2_q;
    endcase
    bit_val = sel_word[sel_q[5:2]];
  end
  always_comb begin
    rdy_d = psel & ~penable;
    err_d = 1'b0;
    rd_d = '0;
    if (psel & ~penable) begin
      case (paddr)
        OFF_MAIN_STATUS: rd_d = {16'h0000, ms_q};
        OFF_SECOND_STATUS: rd_d = {16'h0000, ss_q};
        OFF_MESSAGES_ONE: rd_d = {16'h0000, m1_q};
        OFF_MESSAGES_TWO: rd_d = {16'h0000, m2_q};
        OFF_FREQ_THR_ONE: rd_d = {16'h0000, f_one_q};
        OFF_CURRENT_THR: rd_d = {16'h0000, i_thr_q};
        OFF_DC_LINK_THR: rd_d = {16'h0000, vdc_thr_q};
        OFF_CTRL_UPPER: rd_d = {16'h0000, up_q};
        OFF_CTRL_LOWER: rd_d = {16'h0000, lo_q};
        OFF_FREQ_MIN: rd_d = {16'h0000, fmin_q};
        OFF_FREQ_OFF: rd_d = {16'h0000, foff_q};
        OFF_FREQ_MAX: rd_d = {16'h0000, fmax_q};
        OFF_TORQUE_THR: rd_d = {16'h0000, tthr_q};
        OFF_BIT_SELECT: rd_d = {24'h000000, sel_q[5:2], 2'h0, sel_q[1:0]};
        OFF_BIT_VALUE: rd_d = {31'h00000000, bit_val};
        default: err_d = 1'b1; // Unmapped address
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_q <= '0;
      rdy_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      rd_q <= rd_d;
      rdy_q <= rdy_d;
      err_q <= err_d;
    end
  end
  assign prdata = rd_q;
  assign pready = rdy_q;
  assign pslverr = err_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence apb_setup;
    psel & ~penable;
  endsequence
  sequence apb_done;
    psel & penable & pready;
  endsequence
  chk_access_one_cycle: assert property (apb_setup |=> apb_done)
    else $error("access phase did not complete in one cycle");
  chk_words_hold: assert property (!tick_q |=> $stable({ms_q, ss_q, m1_q, m2_q}))
    else $error("status words changed outside a monitoring tick");
  chk_tick_spacing: assert property (tick_q |=> !tick_q [*8])
    else $error("monitoring ticks too close");
  chk_main_low: assert property (tick_q |=> ms_q[7:0] == $past(fl[7:0]))
    else $error("main status low byte wrong");
  chk_main_flags: assert property (tick_q |=> ms_q[MS_BRAKE] == $past(fl[11]))
    else $error("holding brake bit wrong");
  chk_fmax_bit: assert property (tick_q |=> ms_q[10] == ($past(fa) >= $past(fmax_q)))
    else $error("max frequency bit wrong");
  chk_ctrl_limits: assert property (tick_q |=> ss_q[11] == ($past(ctl) == $past(up_q)))
    else $error("controller upper limit bit wrong");
  chk_freq_setpoint: assert property (m1_q[M1_F_EQ_SET] |-> m1_q[M1_F_GE_SET] & ss_q[6])
    else $error("equal setpoint without at-or-above");
  chk_current_pair: assert property (tick_q |=> ss_q[3] == m1_q[8] && m2_q[8] == !ss_q[3])
    else $error("current threshold bits disagree");
  chk_vdc_pair: assert property (!(ss_q[7] & ss_q[8]) && m1_q[10:9] == ss_q[8:7])
    else $error("dc link bits inconsistent");
  chk_freq_one: assert property (tick_q |=> (ss_q[4] ^ ss_q[5]) &&
    m1_q[2:1] == {ss_q[4], ss_q[5]})
    else $error("first frequency threshold bits wrong");
  chk_load_torque: assert property (tick_q |=> m2_q[12:11] == $past(fl[20:19]))
    else $error("load torque bits wrong");
endmodule

// ### src/dsm_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for levels arriving from outside the pclk domain
module dsm_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q; // First stage, read only by the second
  logic [W-1:0] sync_q; // Second stage, safe to use

  // Both stages clear to zero at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule

// ### verif/dsm_ctrl_model.sv
`timescale 1ns/1ps
// Far-side controller: reads the four words and checks their refresh rhythm
module dsm_ctrl_model
  import dsm_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Words under watch
  input wire logic [15:0] w0,
  input wire logic [15:0] w1,
  input wire logic [15:0] w2,
  input wire logic [15:0] w3,
  // Findings
  output logic off_beat,
  output logic [7:0] upd_cnt
);
  logic [63:0] prev_q; // Words as last seen
  logic [15:0] gap_q; // Cycles since the last change
  logic seen_q; // A change was seen since reset

  ////////////////////////////////////////////////////////////////////////////
  // A change off the monitoring beat means the words did not move together
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= '0;
      gap_q <= 16'h0000;
      seen_q <= 1'b0;
      off_beat <= 1'b0;
      upd_cnt <= 8'h00;
    end else begin
      prev_q <= {w3, w2, w1, w0};
      gap_q <= gap_q + 16'h0001;
      if ({w3, w2, w1, w0} != prev_q) begin
        gap_q <= 16'h0001;
        upd_cnt <= upd_cnt + 8'h01;
        seen_q <= 1'b1;
        // Gap of a multiple of the period only; one word lagging gives a gap of 1
        if (seen_q && (gap_q % MON_CYCLES) != 0) begin
          off_beat <= 1'b1;
        end
      end
    end
  end
endmodule

// ### verif/tb_top.sv
`timescale 1ns/1ps
// Self-checking bench for the drive status words
module tb_top import dsm_pkg::*;;
  // Thresholds written before the table runs
  localparam logic [15:0] F1 = 16'h0100;
  localparam logic [15:0] ITH = 16'h0200;
  localparam logic [15:0] VTH = 16'h0300;
  localparam logic [15:0] CUP = 16'h0400;
  localparam logic [15:0] CLO = 16'hFC00;
  localparam logic [15:0] FMX = 16'h0800;
  typedef struct packed {
    logic [15:0] fa, fs, cur, vdc, ctl, mf;
    logic [3:0] xf; // DC brake, ramp done, load warn, load fault
  } dsm_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, off_beat;
  logic [7:0] paddr, upd_cnt;
  logic [31:0] pwdata, prdata;
  logic [15:0] fa, fs, cur, vdc, ctl, mf, w0, w1, w2, w3, lm;
  logic [3:0] xf;
  int miscompares, check_count;
  // Boundary values sit on each threshold written above in turn
  dsm_row_t rows [5] = '{
    '{16'h0100, 16'h0100, 16'h0200, 16'h0300, 16'h0400, 16'h5A5A, 4'h5},
    '{16'hFF00, 16'h0000, 16'h01FF, 16'h02FF, 16'hFC00, 16'hA5A5, 4'hA},
    '{16'h0101, 16'h0200, 16'hFFFF, 16'h0301, 16'h0000, 16'hFFFF, 4'hF},
    '{16'h0800, 16'h07FF, 16'h0000, 16'h0000, 16'h03FF, 16'h0000, 4'h0},
    '{16'hF7FF, 16'hF800, 16'h0201, 16'hFFFF, 16'hFC01, 16'h8001, 4'h3}};
  logic [7:0] ra [10] = '{OFF_FREQ_THR_ONE, OFF_CURRENT_THR, OFF_DC_LINK_THR, OFF_CTRL_UPPER,
    OFF_CTRL_LOWER, OFF_FREQ_MIN, OFF_FREQ_OFF, OFF_FREQ_MAX, OFF_TORQUE_THR, OFF_BIT_SELECT};
  logic [15:0] rv [10] = '{RST_FREQ_THR_ONE, RST_CURRENT_THR, RST_DC_LINK_THR, RST_CTRL_UPPER,
    RST_CTRL_LOWER, RST_FREQ_MIN, RST_FREQ_OFF, RST_FREQ_MAX, RST_TORQUE_THR, 16'h0000};

  ////////////////////////////////////////////////////////////////////////////
  // Design and far-side model
  dsm_status_top u_dsm_status_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .freq_actual(fa), .freq_setpoint(fs),
    .actual_current_value(cur), .dc_link_voltage(vdc), .torque_actual(16'h0000),
    .controller_output_value(ctl), .st_ready(mf[0]), .st_ready_run(mf[1]),
    .st_running(mf[2]), .st_fault(mf[3]), .coast_stop(mf[4]), .quick_stop(mf[5]),
    .st_inhibit(mf[6]), .st_warning(mf[7]), .st_deviation(mf[8]),
    .process_data_control(mf[9]), .st_current_limit(mf[11]), .st_brake(mf[12]),
    .st_motor_overload(mf[13]), .st_drive_overload(mf[15]), .st_dc_brake(xf[0]),
    .st_ramp_done(xf[1]), .st_no_load(mf[10]), .st_blocked(mf[14]), .st_stalled(1'b0),
    .load_torque_warn(xf[2]), .load_torque_fault(xf[3]), .drive_main_status(w0),
    .drive_second_status(w1), .monitor_messages_one(w2), .monitor_messages_two(w3));
  dsm_ctrl_model u_dsm_ctrl_model (.pclk(pclk), .presetn(presetn), .w0(w0), .w1(w1),
    .w2(w2), .w3(w3), .off_beat(off_beat), .upd_cnt(upd_cnt));

  ////////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // Answer is taken at the rising edge that sees pready high, then released
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk32(32'h0, 32'h1, "no pready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic ee);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    chk32(rd, e, "read data");
    chk32({31'h0, err}, {31'h0, ee}, "error flag");
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
    chk32({31'h0, err}, {31'h0, ee}, "write error flag");
  endtask

  function automatic logic [15:0] mag(input logic [15:0] v);
    return v[15] ? 16'h0000 - v : v;
  endfunction

  // Expected words from the thresholds; only bits that the rules define are compared
  task automatic check_row(input dsm_row_t r);
    logic [15:0] s, o, t;
    lm = r.mf & 16'hBBFF;
    lm[10] = mag(r.fa) >= FMX;
    lm[14] = !r.fa[15] && r.fa != 16'h0000;
    s = {4'h0, r.ctl == CUP, r.ctl == CLO, r.xf[1], r.vdc > VTH, r.vdc < VTH,
         $signed(r.fa) >= $signed(r.fs), mag(r.fa) <= F1, mag(r.fa) > F1, r.cur >= ITH,
         2'b00, r.xf[0]};
    o = {5'h00, s[8], s[7], s[3], r.fa == r.fs, mag(r.fa) > FMX, 1'b0, s[6], 1'b0,
         s[4], s[5], 1'b0};
    t = {3'h0, r.xf[3], r.xf[2], 2'b00, !s[3], 8'h00};
    chk16(w0, lm, "main word");
    chk16(w1 & 16'h0FF9, s, "second word");
    chk16(w2 & 16'h07D6, o, "message word one");
    chk16(w3 & 16'h1900, t, "message word two");
    rdchk(OFF_MAIN_STATUS, {16'h0000, lm}, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog, far longer than the whole sequence
  initial begin
    repeat (20000) @(posedge pclk);
    chk32(32'h0, 32'h1, "watchdog expired");
    end_sim();
  end

  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {fa, fs, cur, vdc, ctl, mf, xf} = '0;
    miscompares = 0;
    check_count = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    chk16(w0 | w1 | w2 | w3, 16'h0000, "words after reset");
    for (int i = 0; i < 10; i++) begin
      rdchk(ra[i], {16'h0000, rv[i]}, 1'b0);
    end
    $display("test reset values done");
    // Read-only and unmapped places
    wr(OFF_MAIN_STATUS, 32'h0000FFFF, 1'b0);
    rdchk(OFF_MAIN_STATUS, 32'h0, 1'b0);
    rdchk(8'h3C, 32'h0, 1'b1);
    wr(8'h3C, 32'h0000FFFF, 1'b1);
    $display("test access kinds done");
    // Upper half of a threshold write is dropped
    wr(OFF_FREQ_THR_ONE, {16'hFFFF, F1}, 1'b0);
    rdchk(OFF_FREQ_THR_ONE, {16'h0000, F1}, 1'b0);
    wr(OFF_CURRENT_THR, {16'h0000, ITH}, 1'b0);
    wr(OFF_DC_LINK_THR, {16'h0000, VTH}, 1'b0);
    wr(OFF_CTRL_UPPER, {16'h0000, CUP}, 1'b0);
    wr(OFF_CTRL_LOWER, {16'h0000, CLO}, 1'b0);
    wr(OFF_FREQ_MAX, {16'h0000, FMX}, 1'b0);
    foreach (rows[i]) begin
      @(posedge pclk);
      {fa, fs, cur, vdc, ctl, mf, xf} <= rows[i];
      // Two-flop sync plus up to one period before the tick lands
      repeat (2 * MON_CYCLES + 5) @(posedge pclk);
      check_row(rows[i]);
      $display("test row %0d done", i);
    end
    // Every main bit through the bit select window
    for (int b = 0; b < 16; b++) begin
      wr(OFF_BIT_SELECT, {24'h0, b[3:0], 4'h0}, 1'b0);
      rdchk(OFF_BIT_VALUE, {31'h0, lm[b]}, 1'b0);
    end
    $display("test bit outputs done");
    chk16({15'h0, off_beat}, 16'h0000, "words moved apart");
    chk16({15'h0, upd_cnt >= 8'h05}, 16'h0001, "update count");
    $display("test refresh rhythm done");
    // Second reset in mid-run
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    chk16(w0 | w1 | w2 | w3, 16'h0000, "words after second reset");
    rdchk(OFF_FREQ_THR_ONE, {16'h0000, RST_FREQ_THR_ONE}, 1'b0);
    $display("test second reset done");
    end_sim();
  end
endmodule
